// [hw/lut_dac_pkg.sv]
// constants and carrier types for the table-driven converter source control
// assumes a byte-level register port fed by an outside 2-wire bus engine
package lut_dac_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG      = 8'h80;
  localparam logic [7:0] ADDR_ROW_OVR     = 8'h81;
  localparam logic [7:0] ADDR_CODE_OVR    = 8'h83;
  localparam logic [7:0] ADDR_SRC_RANGE   = 8'h85;
  localparam logic [7:0] ADDR_UNLOCK      = 8'h86;
  localparam logic [7:0] ADDR_THERMO      = 8'h87;
  localparam logic [7:0] LUT_BASE         = 8'h90;
  localparam logic [7:0] LUT_LAST         = 8'hCF;

  // field positions
  localparam int BIT_CFG_FIXED1   = 7;
  localparam int BIT_POLARITY     = 6;
  localparam int BIT_PERSIST      = 5;
  localparam int BIT_FILT_BYPASS  = 4;
  localparam int BIT_CONV_OVR_SEL = 5;
  localparam int BIT_TBL_OVR_SEL  = 4;
  localparam int BIT_UNLOCK       = 7;

  // unlock register command bytes
  localparam logic [7:0] UNLOCK_SET   = 8'h80;
  localparam logic [7:0] UNLOCK_CLEAR = 8'h00;

  // full-scale range codes
  localparam logic [1:0] RANGE_RSVD = 2'h0;
  localparam logic [1:0] RANGE_LOW  = 2'h1;
  localparam logic [1:0] RANGE_MID  = 2'h2;
  localparam logic [1:0] RANGE_HIGH = 2'h3;

  // settle filter: identical conversions needed at power-up
  localparam int FILTER_MATCHES = 4;

  localparam logic [7:0] DAC_IDLE = 8'h00;

  typedef struct packed {
    logic       current_polarity_bit;
    logic       override_persistence_bit;
    logic       conversion_filter_bypass;
    logic       table_override_select;
    logic       converter_override_select;
    logic [1:0] full_scale_field;
    logic [5:0] table_row_override_bits;
    logic [7:0] converter_override_bits;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{
    current_polarity_bit:      1'b0,
    override_persistence_bit:  1'b0,
    conversion_filter_bypass:  1'b0,
    table_override_select:     1'b0,
    converter_override_select: 1'b0,
    full_scale_field:          RANGE_HIGH,
    table_row_override_bits:   6'h00,
    converter_override_bits:   8'h00
  };

  typedef enum logic [4:0] {
    PU_RECALL  = 5'b00001,
    PU_ANALOG  = 5'b00010,
    PU_ADC_ON  = 5'b00100,
    PU_FILTER  = 5'b01000,
    PU_RUN     = 5'b10000
  } powerup_e;

endpackage

// [hw/lut_store.sv]
// 64-row byte table: one write port, two asynchronous read ports
// assumes writes are already qualified by the unlock latch
`timescale 1ns/1ps
module lut_store #(
  parameter int ROWS = 64
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // write port
  input  wire logic                    wr_en,
  input  wire logic [$clog2(ROWS)-1:0] wr_row,
  input  wire logic [7:0]              wr_byte,
  // read ports
  input  wire logic [$clog2(ROWS)-1:0] sel_row,
  output logic      [7:0]              sel_byte,
  input  wire logic [$clog2(ROWS)-1:0] bus_row,
  output logic      [7:0]              bus_byte
);
  logic [7:0] mem_reg  [ROWS];
  logic [7:0] mem_next [ROWS];

  always_comb
  begin
    for (int i = 0; i < ROWS; i++)
    begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en)
    begin
      mem_next[wr_row] = wr_byte;
    end
  end

  // rows come up cleared, as shipped
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < ROWS; i++)
    begin
      mem_reg[i] <= reset ? 8'h00 : mem_next[i];
    end
  end

  assign sel_byte = mem_reg[sel_row];
  assign bus_byte = mem_reg[bus_row];
endmodule

// [hw/conv_filter.sv]
// thermometer converter capture: samples the converter clock pin and code,
// flags each completed conversion and counts identical results
// assumes the code pins are stable around the converter clock rising edge
`timescale 1ns/1ps
module conv_filter #(
  parameter int MATCHES = lut_dac_pkg::FILTER_MATCHES
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // converter pins
  input  wire logic       adc_clk,
  input  wire logic [7:0] adc_code,
  // control
  input  wire logic       enable,
  input  wire logic       bypass,
  // results
  output logic            conv_done,
  output logic      [7:0] conv_code,
  output logic            settled
);
  import lut_dac_pkg::*;

  logic [2:0] clk_sync_reg;
  logic [2:0] clk_sync_next;
  logic [7:0] code_s1_reg;
  logic [7:0] code_s2_reg;
  logic [7:0] code_reg;
  logic [7:0] code_next;
  logic [2:0] match_reg;
  logic [2:0] match_next;
  logic       done_reg;
  logic       done_next;
  logic       edge_seen;
  logic [2:0] need;

  always_comb
  begin
    clk_sync_next = {clk_sync_reg[1:0], adc_clk};
    edge_seen     = clk_sync_reg[1] && !clk_sync_reg[2];
    need          = bypass ? 3'd1 : 3'(MATCHES);
    code_next     = code_reg;
    match_next    = match_reg;
    done_next     = 1'b0;
    if (!enable)
    begin
      match_next = 3'd0;
    end
    else if (edge_seen)
    begin
      done_next = 1'b1;
      code_next = code_s2_reg;
      // consecutive identical results, saturating at the target
      if (match_reg != 3'd0 && code_s2_reg == code_reg)
      begin
        match_next = (match_reg >= need) ? match_reg : match_reg + 3'd1;
      end
      else
      begin
        match_next = 3'd1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      clk_sync_reg <= 3'h0;
      code_s1_reg  <= 8'h00;
      code_s2_reg  <= 8'h00;
      code_reg     <= 8'h00;
      match_reg    <= 3'h0;
      done_reg     <= 1'b0;
    end
    else
    begin
      clk_sync_reg <= clk_sync_next;
      code_s1_reg  <= adc_code;
      code_s2_reg  <= code_s1_reg;
      code_reg     <= code_next;
      match_reg    <= match_next;
      done_reg     <= done_next;
    end
  end

  assign conv_done = done_reg;
  assign conv_code = code_reg;
  assign settled   = enable && (match_reg >= need);

  property p_filter_need;
    @(posedge sys_clk) disable iff (reset)
      (settled && !bypass) |-> (match_reg >= 3'd4);
  endproperty
  a_filter_need: assert property (p_filter_need)
    else $error("settled before four identical conversions");
endmodule

// [hw/lut_dac_source_control.sv]
// top of the converter source control: register file, power-up sequence,
// source selection. assumes an outside bus engine delivers one data byte
// per wr_stb with its address, and samples wr_ack for the acknowledge.
`timescale 1ns/1ps
module lut_dac_source_control (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // register write port
  input  wire logic       wr_stb,
  input  wire logic       wr_first,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic            wr_ack,
  // register read port
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  // supply threshold pins
  input  wire logic       first_supply_threshold,
  input  wire logic       converter_supply_threshold,
  // thermometer converter pins
  input  wire logic       adc_clk,
  input  wire logic [7:0] adc_code,
  output logic            adc_enable,
  output logic            analog_enable,
  // current generator control
  output logic      [7:0] dac_code,
  output logic            range_low,
  output logic            range_mid,
  output logic            range_high,
  output logic            current_sink
);
  import lut_dac_pkg::*;

  function automatic logic in_table(input logic [7:0] a);
    in_table = (a >= LUT_BASE) && (a <= LUT_LAST);
  endfunction

  function automatic logic [5:0] table_row(input logic [7:0] a);
    table_row = 6'(a - LUT_BASE);
  endfunction

  // supply pins pass two flip-flops
  logic [1:0] por_sync_reg;
  logic [1:0] adcok_sync_reg;
  logic       por_ok;
  logic       adc_ok;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      por_sync_reg   <= 2'b00;
      adcok_sync_reg <= 2'b00;
    end
    else
    begin
      por_sync_reg   <= {por_sync_reg[0], first_supply_threshold};
      adcok_sync_reg <= {adcok_sync_reg[0], converter_supply_threshold};
    end
  end
  assign por_ok = por_sync_reg[1];
  assign adc_ok = adcok_sync_reg[1];

  // control state
  ctrl_s      work_reg;
  ctrl_s      work_next;
  ctrl_s      stored_reg;
  ctrl_s      stored_next;
  logic       unlock_reg;
  logic       unlock_next;
  logic [7:0] start_addr_reg;
  logic [7:0] start_addr_next;
  logic [7:0] thermo_reg;
  logic [7:0] thermo_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  powerup_e   state_reg;
  powerup_e   state_next;
  logic [7:0] dac_reg;
  logic [7:0] dac_next;
  logic [3:0] out_reg;
  logic [3:0] out_next;

  logic       wr_do;
  logic       follow_blocked;
  logic       conv_done;
  logic [7:0] conv_code;
  logic       settled;
  logic [5:0] sel_row;
  logic [7:0] sel_addr;
  logic [7:0] sel_byte;
  logic [7:0] bus_byte;

  // acknowledge decision
  always_comb
  begin
    start_addr_next = (wr_stb && wr_first) ? wr_addr : start_addr_reg;
    follow_blocked  = !wr_first && (start_addr_reg == ADDR_CONFIG ||
                      start_addr_reg == ADDR_SRC_RANGE ||
                      start_addr_reg == ADDR_UNLOCK);
    wr_ack = wr_stb && !follow_blocked &&
             (unlock_reg || (wr_first && wr_addr == ADDR_UNLOCK));
    wr_do  = wr_ack;
  end

  // register writes and power-up recall
  always_comb
  begin
    work_next   = work_reg;
    stored_next = stored_reg;
    unlock_next = unlock_reg;
    if (state_reg == PU_RECALL)
    begin
      work_next = stored_reg;
    end
    else if (wr_do)
    begin
      case (wr_addr)
        ADDR_CONFIG:
        begin
          work_next.current_polarity_bit     = wr_data[BIT_POLARITY];
          work_next.override_persistence_bit = wr_data[BIT_PERSIST];
          work_next.conversion_filter_bypass = wr_data[BIT_FILT_BYPASS];
          stored_next.current_polarity_bit     = wr_data[BIT_POLARITY];
          stored_next.override_persistence_bit = wr_data[BIT_PERSIST];
          stored_next.conversion_filter_bypass = wr_data[BIT_FILT_BYPASS];
        end
        ADDR_ROW_OVR:
        begin
          work_next.table_row_override_bits = wr_data[5:0];
          if (work_reg.override_persistence_bit)
          begin
            stored_next.table_row_override_bits = wr_data[5:0];
          end
        end
        ADDR_CODE_OVR:
        begin
          work_next.converter_override_bits = wr_data;
          if (work_reg.override_persistence_bit)
          begin
            stored_next.converter_override_bits = wr_data;
          end
        end
        ADDR_SRC_RANGE:
        begin
          work_next.converter_override_select = wr_data[BIT_CONV_OVR_SEL];
          work_next.table_override_select     = wr_data[BIT_TBL_OVR_SEL];
          work_next.full_scale_field          = wr_data[1:0];
          stored_next.converter_override_select = wr_data[BIT_CONV_OVR_SEL];
          stored_next.table_override_select     = wr_data[BIT_TBL_OVR_SEL];
          stored_next.full_scale_field          = wr_data[1:0];
        end
        ADDR_UNLOCK:
        begin
          // only the latch moves; the rest of the register stays zero
          if (wr_data == UNLOCK_SET)
          begin
            unlock_next = 1'b1;
          end
          else if (wr_data == UNLOCK_CLEAR)
          begin
            unlock_next = 1'b0;
          end
        end
        default:
        begin
          work_next = work_reg;
        end
      endcase
    end
  end

  // stored image models the nonvolatile cells; reset stands for first use
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      work_reg       <= CTRL_RESET;
      stored_reg     <= CTRL_RESET;
      unlock_reg     <= 1'b0;
      start_addr_reg <= 8'h00;
    end
    else
    begin
      work_reg       <= work_next;
      stored_reg     <= stored_next;
      unlock_reg     <= unlock_next;
      start_addr_reg <= start_addr_next;
    end
  end

  lut_store #(
    .ROWS (64)
  ) u_table (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .wr_en    (wr_do && in_table(wr_addr)),
    .wr_row   (table_row(wr_addr)),
    .wr_byte  (wr_data),
    .sel_row  (table_row(sel_addr)),
    .sel_byte (sel_byte),
    .bus_row  (table_row(rd_addr)),
    .bus_byte (bus_byte)
  );

  conv_filter #(
    .MATCHES (FILTER_MATCHES)
  ) u_conv (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .adc_clk   (adc_clk),
    .adc_code  (adc_code),
    .enable    (adc_enable),
    .bypass    (work_reg.conversion_filter_bypass),
    .conv_done (conv_done),
    .conv_code (conv_code),
    .settled   (settled)
  );

  // source selection, power-up sequence and outputs
  always_comb
  begin
    thermo_next = conv_done ? conv_code : thermo_reg;
    sel_row = work_reg.table_override_select ?
              work_reg.table_row_override_bits :
              thermo_reg[7:2];
    sel_addr = 8'(LUT_BASE + {2'b00, sel_row});
    state_next = state_reg;
    case (state_reg)
      PU_RECALL:
        state_next = por_ok ? PU_ANALOG : PU_RECALL;
      PU_ANALOG:
        state_next = adc_ok ? PU_ADC_ON : PU_ANALOG;
      PU_ADC_ON:
        // an override source needs no settled conversion
        state_next = (work_reg.converter_override_select ||
                      work_reg.table_override_select) ?
                     PU_RUN : PU_FILTER;
      PU_FILTER:
        state_next = settled ? PU_RUN : PU_FILTER;
      PU_RUN:
        state_next = PU_RUN;
      default:
        state_next = PU_RECALL;
    endcase
    if (!por_ok)
    begin
      state_next = PU_RECALL;
    end
    if (state_reg != PU_RUN)
    begin
      dac_next = DAC_IDLE;
    end
    else if (work_reg.converter_override_select)
    begin
      dac_next = work_reg.converter_override_bits;
    end
    else
    begin
      dac_next = sel_byte;
    end
    out_next = {work_reg.full_scale_field == RANGE_LOW,
                work_reg.full_scale_field == RANGE_MID,
                work_reg.full_scale_field == RANGE_HIGH,
                work_reg.current_polarity_bit};
    if (in_table(rd_addr))
    begin
      rd_data_next = bus_byte;
    end
    else
    begin
      case (rd_addr)
        ADDR_CONFIG:
          rd_data_next = {1'b1, work_reg.current_polarity_bit,
                          work_reg.override_persistence_bit,
                          work_reg.conversion_filter_bypass, 4'h0};
        ADDR_ROW_OVR:
          rd_data_next = {2'b00, work_reg.table_row_override_bits};
        ADDR_CODE_OVR:
          rd_data_next = work_reg.converter_override_bits;
        ADDR_SRC_RANGE:
          rd_data_next = {2'b00, work_reg.converter_override_select,
                          work_reg.table_override_select, 2'b00,
                          work_reg.full_scale_field};
        ADDR_UNLOCK:
          rd_data_next = {unlock_reg, 7'h00};
        ADDR_THERMO:
          rd_data_next = thermo_reg;
        default:
          rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg   <= PU_RECALL;
      dac_reg     <= DAC_IDLE;
      thermo_reg  <= 8'h00;
      out_reg     <= 4'b0010;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      state_reg   <= state_next;
      dac_reg     <= dac_next;
      thermo_reg  <= thermo_next;
      out_reg     <= out_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign analog_enable = (state_reg != PU_RECALL);
  assign adc_enable    = (state_reg == PU_ADC_ON) ||
                         (state_reg == PU_FILTER) || (state_reg == PU_RUN);
  assign dac_code      = dac_reg;
  assign range_low     = out_reg[3];
  assign range_mid     = out_reg[2];
  assign range_high    = out_reg[1];
  assign current_sink  = out_reg[0];
  assign rd_data       = rd_data_reg;

  property p_hold_zero;
    @(posedge sys_clk) disable iff (reset)
      (state_reg != PU_RUN) |=> (dac_code == 8'h00);
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("converter input not zero during power-up");

  property p_conv_override;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == PU_RUN && work_reg.converter_override_select)
      |=> (dac_code == $past(work_reg.converter_override_bits));
  endproperty
  a_conv_override: assert property (p_conv_override)
    else $error("override byte not on converter input");

  property p_table_source;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == PU_RUN && !work_reg.converter_override_select)
      |=> (dac_code == $past(sel_byte));
  endproperty
  a_table_source: assert property (p_table_source)
    else $error("table byte not on converter input");

  property p_row_select;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |-> (sel_addr == (work_reg.table_override_select ?
               8'h90 + {2'b00, work_reg.table_row_override_bits} :
               8'h90 + {2'b00, thermo_reg[7:2]}));
  endproperty
  a_row_select: assert property (p_row_select)
    else $error("wrong table row address");

  property p_locked_write;
    @(posedge sys_clk) disable iff (reset)
      (wr_stb && !unlock_reg && wr_addr != ADDR_UNLOCK) |-> !wr_ack;
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("write acknowledged while locked");

  property p_unlock_set;
    @(posedge sys_clk) disable iff (reset)
      (wr_stb && wr_first && wr_addr == ADDR_UNLOCK &&
       wr_data == UNLOCK_SET) |=> unlock_reg ##1
      ($past(rd_addr) != ADDR_UNLOCK || rd_data[7:0] == 8'h80);
  endproperty
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlock latch not set by unlock byte");

  property p_status_hold;
    @(posedge sys_clk) disable iff (reset)
      !conv_done |=> $stable(thermo_reg);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("thermometer status changed without conversion");

  property p_range_mid;
    @(posedge sys_clk) disable iff (reset)
      (work_reg.full_scale_field == RANGE_MID)
      |=> (range_mid && !range_low && !range_high);
  endproperty
  a_range_mid: assert property (p_range_mid)
    else $error("middle range not decoded");

  property p_polarity;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |=> (current_sink == $past(work_reg.current_polarity_bit));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("current polarity does not follow control bit");

  property p_recall;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == PU_RECALL) |=> (work_reg == $past(stored_reg));
  endproperty
  a_recall: assert property (p_recall)
    else $error("stored control bits not recalled");
endmodule

// [bench/host_master.sv]
// bus master model: byte-level write requests toward the register port
// assumes xfer is entered just after a rising sys_clk edge
`timescale 1ns/1ps
module host_master (
  // clock
  input  wire logic       sys_clk,
  // write request and acknowledge
  output logic            wr_stb,
  output logic            wr_first,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  input  wire logic       wr_ack
);
  initial
  begin
    wr_stb = 1'b0;
    wr_first = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end

  // holds the byte until the sampling edge, then takes the acknowledge
  task automatic xfer(input logic f, input logic [7:0] a, d,
                      output logic ack);
    wr_stb <= 1'b1;
    wr_first <= f;
    wr_addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    ack = wr_ack;
    wr_stb <= 1'b0;
    wr_first <= 1'b0;
    // released lines do not keep the last byte
    wr_addr <= ~a;
    wr_data <= ~d;
    @(posedge sys_clk);
  endtask
endmodule

// [bench/lut_dac_source_control_tb.sv]
// testbench for the converter source control
// assumes the byte-level register port and a free-running converter clock
`timescale 1ns/1ps
module lut_dac_source_control_tb;
  import lut_dac_pkg::*;
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] dac;
    logic [2:0] rng;
  } row_s;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       wr_stb, wr_first, wr_ack, ack;
  logic [7:0] wr_addr, wr_data, rd_data, dac_code;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] adc_code = 8'hA4;
  logic       adc_clk = 1'b0;
  // supply already above the first threshold when reset lifts
  logic       first_supply_threshold = 1'b1;
  logic       converter_supply_threshold = 1'b0;
  logic       adc_enable, analog_enable, current_sink;
  logic       range_low, range_mid, range_high;
  int         errors = 0;
  int         tests_run = 0;
  // source select byte, expected converter input, expected range lines
  row_s       rows [4] = '{'{8'h11, 8'hC3, 3'h4}, '{8'h02, 8'h5A, 3'h2},
                           '{8'h23, 8'h77, 3'h1}, '{8'h31, 8'h77, 3'h4}};

  lut_dac_source_control u_dut (.sys_clk, .reset, .wr_stb, .wr_first,
    .wr_addr, .wr_data, .wr_ack, .rd_addr, .rd_data,
    .first_supply_threshold, .converter_supply_threshold, .adc_clk,
    .adc_code, .adc_enable, .analog_enable, .dac_code, .range_low,
    .range_mid, .range_high, .current_sink);
  host_master u_host (.sys_clk, .wr_stb, .wr_first, .wr_addr, .wr_data,
    .wr_ack);

  always #25 sys_clk = ~sys_clk;
  initial
  begin
    #7;
    forever #200 adc_clk = ~adc_clk;
  end

  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic f, input logic [7:0] a, d, input logic e);
    u_host.xfer(f, a, d, ack);
    chk({7'h00, ack}, {7'h00, e});
  endtask
  task automatic rd(input logic [7:0] a, e);
    rd_addr <= a;
    repeat (2) @(posedge sys_clk);
    chk(rd_data, e);
  endtask
  task automatic wait_dac(input logic [7:0] e);
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (dac_code !== e && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(dac_code, e);
  endtask
  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(dac_code, DAC_IDLE);
    chk({5'h00, range_low, range_mid, range_high}, 8'h01);
    chk({7'h00, current_sink}, 8'h00);
    chk({6'h00, adc_enable, analog_enable}, 8'h00);
    rd(ADDR_UNLOCK, 8'h00);
    rd(ADDR_SRC_RANGE, 8'h03);
    wr(1'b1, 8'hB9, 8'h5A, 1'b0);
    wr(1'b1, ADDR_UNLOCK, UNLOCK_SET, 1'b1);
    rd(ADDR_UNLOCK, 8'h80);
    wr(1'b1, 8'hB9, 8'h5A, 1'b1);
    wr(1'b1, LUT_BASE + 8'h03, 8'hC3, 1'b1);
    wr(1'b1, ADDR_ROW_OVR, 8'h03, 1'b1);
    wr(1'b1, ADDR_CODE_OVR, 8'h77, 1'b1);
    chk(dac_code, DAC_IDLE);
    chk({6'h00, adc_enable, analog_enable}, 8'h01);
    converter_supply_threshold <= 1'b1;
    wait_dac(8'h5A);
    chk({6'h00, adc_enable, analog_enable}, 8'h03);
    wr(1'b1, ADDR_THERMO, 8'h00, 1'b1);
    rd(ADDR_THERMO, 8'hA4);
    foreach (rows[i])
    begin
      wr(1'b1, ADDR_SRC_RANGE, rows[i].sel, 1'b1);
      wait_dac(rows[i].dac);
      chk({5'h00, range_low, range_mid, range_high},
          {5'h00, rows[i].rng});
    end
    wr(1'b1, ADDR_SRC_RANGE, 8'h03, 1'b1);
    wr(1'b0, ADDR_UNLOCK, UNLOCK_CLEAR, 1'b0);
    rd(ADDR_UNLOCK, 8'h80);
    wr(1'b1, ADDR_CONFIG, 8'hD0, 1'b1);
    @(posedge sys_clk);
    chk({7'h00, current_sink}, 8'h01);
    wr(1'b1, ADDR_UNLOCK, UNLOCK_CLEAR, 1'b1);
    wr(1'b1, ADDR_ROW_OVR, 8'h05, 1'b0);
    rd(ADDR_ROW_OVR, 8'h03);
    adc_code <= 8'h0C;
    wait_dac(8'hC3);
    rd(ADDR_THERMO, 8'h0C);
    // supply dip: recall, then one conversion suffices with bypass set
    first_supply_threshold <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(dac_code, DAC_IDLE);
    chk({6'h00, adc_enable, analog_enable}, 8'h00);
    first_supply_threshold <= 1'b1;
    repeat (22) @(posedge sys_clk);
    chk(dac_code, 8'hC3);
    chk({7'h00, current_sink}, 8'h01);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(dac_code, DAC_IDLE);
    rd(ADDR_UNLOCK, 8'h00);
    end_sim();
  end
endmodule
